// File: logic/fpled_pkg.sv
package fpled_pkg;
    // lamp colour codes
    localparam logic [1:0] LAMP_DARK = 2'h0;
    localparam logic [1:0] LAMP_AMBER = 2'h1;
    localparam logic [1:0] LAMP_GREEN = 2'h2;
    localparam logic [1:0] LAMP_RED = 2'h3;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATE = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

    // control bits, write-only pulses
    localparam int CTRL_ARM = 0;
    localparam int CTRL_ABORT = 1;
    localparam int CTRL_DEV_RESET = 2;

    // event bits shared by status and mask
    localparam int EV_PLL = 0;
    localparam int EV_POWER = 1;
    localparam int EV_TEMP = 2;
    localparam int EV_CAL_FAIL = 3;
    localparam int EV_TRIGGER = 4;
    localparam int EV_BURST_DONE = 5;
    localparam int EV_W = 6;
    localparam logic [EV_W-1:0] IRQ_MASK_RESET = 6'h00;

    // state register field positions
    localparam int ST_ACT_LSB = 0;
    localparam int ST_ERR_LSB = 4;
    localparam int ST_CAL_ERR = 7;
    localparam int ST_ENABLED = 8;
    localparam int ST_ACC_LAMP_LSB = 12;
    localparam int ST_ACT_LAMP_LSB = 14;

    typedef enum logic [1:0] {
        FPLED_IDLE,
        FPLED_ARMED,
        FPLED_BURST
    } fpled_act_t;
endpackage

// File: logic/fpled_status.sv
// Operation
// - access lamp dark until the device is functional
// - access lamp amber while host software accesses the device
// - access lamp green when functional, ready and not being accessed
// - activity lamp dark when parametric, or idle without error
// - activity lamp amber while armed, awaiting the start trigger
// - activity lamp green from start trigger through the pattern burst
// - calibration failure keeps lamp green, error held until pass or reset
// - activity lamp red whenever in an error condition
// - refuse to operate while in error until cleared or reset
// - pll unlock is a sticky error cleared only by device reset
// - power trip disables device, sticky until device reset
// - temperature trip disables device, cleared by reset or power cycle
//
// Chosen here: the address-and-strobe port and the register offsets.
module fpled_status
    import fpled_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [fpled_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fpled_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [fpled_pkg::DATA_W-1:0] reg_rdata,
    input wire logic functional,
    input wire logic host_access,
    input wire logic pin_parametric_measure_mode,
    input wire logic start_trigger,
    input wire logic burst_done,
    input wire logic cal_fail,
    input wire logic cal_pass,
    input wire logic pll_unlock,
    input wire logic power_trip,
    input wire logic temp_trip,
    input wire logic utility_reset,
    output logic device_enable,
    output logic [1:0] access_lamp,
    output logic [1:0] activity_lamp,
    output logic irq
);
    import fpled_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    fpled_act_t act;
    fpled_act_t next_act;
    logic err_pll;
    logic err_power;
    logic err_temp;
    logic cal_err;
    logic next_err_pll;
    logic next_err_power;
    logic next_err_temp;
    logic next_cal_err;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] next_irq_status;
    logic [EV_W-1:0] irq_mask;
    logic [EV_W-1:0] next_irq_mask;
    logic [DATA_W-1:0] next_reg_rdata;
    logic [1:0] next_access_lamp;
    logic [1:0] next_activity_lamp;
    logic in_error;
    logic ctrl_wr;
    logic dev_reset;
    logic arm_req;
    logic abort_req;
    logic [EV_W-1:0] events;

    assign ctrl_wr = reg_wr && hit(reg_addr, REG_CTRL);
    assign dev_reset = utility_reset || (ctrl_wr && reg_wdata[CTRL_DEV_RESET]);
    assign arm_req = ctrl_wr && reg_wdata[CTRL_ARM];
    assign abort_req = ctrl_wr && reg_wdata[CTRL_ABORT];
    assign in_error = err_pll || err_power || err_temp;
    // a live trip keeps the device off even in the reset cycle
    assign device_enable = !in_error && !power_trip && !temp_trip;
    assign irq = |(irq_status & irq_mask);

    always_comb begin
        events = '0;
        events[EV_PLL] = pll_unlock;
        events[EV_POWER] = power_trip;
        events[EV_TEMP] = temp_trip;
        events[EV_CAL_FAIL] = cal_fail;
        // counted only when the engine really starts, not on a refused trigger
        events[EV_TRIGGER] = act == FPLED_ARMED && next_act == FPLED_BURST;
        events[EV_BURST_DONE] = burst_done && act == FPLED_BURST;
    end

    // sticky error flags: only a device reset clears (cal_err also by cal_pass), a live source wins
    always_comb begin
        next_err_pll = err_pll;
        next_err_power = err_power;
        next_err_temp = err_temp;
        next_cal_err = cal_err;
        if (dev_reset) begin
            next_err_pll = 1'b0;
            next_err_power = 1'b0;
            next_err_temp = 1'b0;
            next_cal_err = 1'b0;
        end
        if (cal_pass) begin
            next_cal_err = 1'b0;
        end
        if (pll_unlock) begin
            next_err_pll = 1'b1;
        end
        if (power_trip) begin
            next_err_power = 1'b1;
        end
        if (temp_trip) begin
            next_err_temp = 1'b1;
        end
        if (cal_fail) begin
            next_cal_err = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            err_pll <= 1'b0;
            err_power <= 1'b0;
            err_temp <= 1'b0;
            cal_err <= 1'b0;
        end else begin
            err_pll <= next_err_pll;
            err_power <= next_err_power;
            err_temp <= next_err_temp;
            cal_err <= next_cal_err;
        end
    end

    // pattern engine sequencing
    always_comb begin
        next_act = act;
        case (act)
            FPLED_IDLE: begin
                if (arm_req && device_enable && !dev_reset &&
                    !pin_parametric_measure_mode) begin
                    next_act = FPLED_ARMED;
                end
            end
            FPLED_ARMED: begin
                if (start_trigger) begin
                    next_act = FPLED_BURST;
                end
            end
            FPLED_BURST: begin
                if (burst_done) begin
                    next_act = FPLED_IDLE;
                end
            end
            default: begin
                next_act = FPLED_IDLE;
            end
        endcase
        if (abort_req || dev_reset || !device_enable) begin
            next_act = FPLED_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            act <= FPLED_IDLE;
        end else begin
            act <= next_act;
        end
    end

    // lamp colour selection
    always_comb begin
        if (!functional) begin
            next_access_lamp = LAMP_DARK;
        end else if (host_access || reg_wr || reg_rd) begin
            next_access_lamp = LAMP_AMBER;
        end else begin
            next_access_lamp = LAMP_GREEN;
        end
        if (in_error) begin
            next_activity_lamp = LAMP_RED;
        end else if (pin_parametric_measure_mode) begin
            next_activity_lamp = LAMP_DARK;
        end else begin
            case (act)
                FPLED_ARMED: next_activity_lamp = LAMP_AMBER;
                // a calibration failure leaves the lamp green, not red
                FPLED_BURST: next_activity_lamp = LAMP_GREEN;
                default: next_activity_lamp = LAMP_DARK;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            access_lamp <= LAMP_DARK;
            activity_lamp <= LAMP_DARK;
        end else begin
            access_lamp <= next_access_lamp;
            activity_lamp <= next_activity_lamp;
        end
    end

    // interrupt status: write one to clear, a same-cycle event wins
    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        if (reg_wr && hit(reg_addr, REG_IRQ_STATUS)) begin
            next_irq_status = irq_status & ~reg_wdata[EV_W-1:0];
        end
        if (reg_wr && hit(reg_addr, REG_IRQ_MASK)) begin
            next_irq_mask = reg_wdata[EV_W-1:0];
        end
        next_irq_status = next_irq_status | events;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_status <= '0;
            irq_mask <= IRQ_MASK_RESET;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_comb begin
        next_reg_rdata = '0;
        if (reg_rd) begin
            if (hit(reg_addr, REG_STATE)) begin
                next_reg_rdata[ST_ACT_LSB +: 2] = act;
                next_reg_rdata[ST_ERR_LSB] = err_pll;
                next_reg_rdata[ST_ERR_LSB + 1] = err_power;
                next_reg_rdata[ST_ERR_LSB + 2] = err_temp;
                next_reg_rdata[ST_CAL_ERR] = cal_err;
                next_reg_rdata[ST_ENABLED] = device_enable;
                next_reg_rdata[ST_ACC_LAMP_LSB +: 2] = access_lamp;
                next_reg_rdata[ST_ACT_LAMP_LSB +: 2] = activity_lamp;
            end else if (hit(reg_addr, REG_IRQ_STATUS)) begin
                next_reg_rdata[EV_W-1:0] = irq_status;
            end else if (hit(reg_addr, REG_IRQ_MASK)) begin
                next_reg_rdata[EV_W-1:0] = irq_mask;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end
endmodule

// File: sim/fpled_status_monitor.sv
module fpled_status_monitor
    import fpled_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic functional,
    input wire logic host_access,
    input wire logic pll_unlock,
    input wire logic power_trip,
    input wire logic temp_trip,
    input wire logic device_enable,
    input wire logic [1:0] access_lamp,
    input wire logic [1:0] activity_lamp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_busy;
        functional && (host_access || reg_wr || reg_rd);
    endsequence
    sequence s_pll;
        pll_unlock ##1 !device_enable;
    endsequence
    sequence s_power;
        power_trip ##1 !device_enable;
    endsequence
    AST_ACC_DARK: assert property (!functional |=> access_lamp == LAMP_DARK)
        else $error("access lamp lit while not functional");
    AST_ACC_AMBER: assert property (s_busy |=> access_lamp == LAMP_AMBER)
        else $error("access lamp not amber during access");
    AST_ACC_GREEN: assert property (functional && !host_access && !reg_wr
        && !reg_rd |=> access_lamp == LAMP_GREEN)
        else $error("access lamp not green when ready");
    AST_PLL_RED: assert property (s_pll |=> activity_lamp == LAMP_RED)
        else $error("pll error not shown red");
    AST_POWER_RED: assert property (s_power |=> activity_lamp == LAMP_RED)
        else $error("power error not shown red");
    AST_PWR_OFF: assert property (power_trip |-> !device_enable)
        else $error("enabled during power trip");
    AST_TEMP_OFF: assert property (temp_trip |=> !device_enable
        ##1 activity_lamp == LAMP_RED)
        else $error("temperature trip not held");
    AST_ERR_HOLD: assert property ($past(rstn) && $past(pll_unlock)
        |-> !device_enable)
        else $error("enabled with pll error set");
endmodule

bind fpled_status fpled_status_monitor u_mon (.core_clk(core_clk),
    .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .functional(functional),
    .host_access(host_access), .pll_unlock(pll_unlock),
    .power_trip(power_trip), .temp_trip(temp_trip),
    .device_enable(device_enable), .access_lamp(access_lamp),
    .activity_lamp(activity_lamp));

// File: sim/fpled_lamp_model.sv
module fpled_lamp_model
    import fpled_pkg::*;
(
    input wire logic [1:0] access_lamp,
    input wire logic [1:0] activity_lamp,
    output logic acc_lit,
    output logic act_red
);
    timeunit 1ns;
    timeprecision 1ps;
    assign acc_lit = access_lamp != LAMP_DARK;
    assign act_red = activity_lamp == LAMP_RED;
endmodule

// File: sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpled_pkg::*;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    bad_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
    logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic functional = 1'b0, host_access = 1'b0, para = 1'b0;
    logic [7:0] reg_addr = 8'h00, ev = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, rdat, reg_rdata;
    logic device_enable, irq, acc_lit, act_red;
    logic [1:0] access_lamp, activity_lamp, e;
    int bad_count = 0, cmp_count = 0;
    integer m_act = 0, m_err = 0;
    int trip_q[$] = '{EV_PLL, EV_POWER, EV_TEMP};
    fpled_status dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .functional(functional),
        .host_access(host_access), .pin_parametric_measure_mode(para),
        .start_trigger(ev[0]), .burst_done(ev[1]), .cal_fail(ev[2]),
        .cal_pass(ev[3]), .pll_unlock(ev[4]), .power_trip(ev[5]),
        .temp_trip(ev[6]), .utility_reset(ev[7]),
        .device_enable(device_enable), .access_lamp(access_lamp),
        .activity_lamp(activity_lamp), .irq(irq));
    fpled_lamp_model u_lamp (.access_lamp(access_lamp),
        .activity_lamp(activity_lamp), .acc_lit(acc_lit), .act_red(act_red));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // one-cycle event pulse; level trips are only held one cycle too
    task automatic pulse(input int k);
        @(posedge core_clk);
        ev[k] <= 1'b1;
        @(posedge core_clk);
        ev <= 8'h00;
    endtask
    task automatic chk_act;
        e = m_err ? LAMP_RED : m_act == 1 ? LAMP_AMBER :
            m_act == 2 ? LAMP_GREEN : LAMP_DARK;
        `CHK("activity", e, activity_lamp)
    endtask
    task automatic complete_run;
        $display("counts: %0d compares, %0d bad", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100us;
        bad_count++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hdc90_2758));
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            functional <= i[0];
            host_access <= i < 5 ? 1'($urandom % 2) : 1'b0;
            tick(1);
            e = !functional ? LAMP_DARK : host_access ? LAMP_AMBER : LAMP_GREEN;
            `CHK("access", e, access_lamp)
            `CHK("lit", functional, acc_lit)
        end
        $display("test access done");
        wr(REG_CTRL, 32'h0000_0001);
        m_act = 1;
        tick(1);
        chk_act();
        pulse(0);
        m_act = 2;
        tick(1);
        chk_act();
        pulse(2);
        tick(1);
        chk_act();
        rd(REG_STATE, rdat);
        `CHK("cal err", 1'b1, rdat[ST_CAL_ERR])
        pulse(3);
        rd(REG_STATE, rdat);
        `CHK("cal clr", 1'b0, rdat[ST_CAL_ERR])
        pulse(1);
        m_act = 0;
        tick(1);
        chk_act();
        @(posedge core_clk);
        para <= 1'b1;
        wr(REG_CTRL, 32'h0000_0001);
        tick(1);
        chk_act();
        rd(REG_STATE, rdat);
        `CHK("para refused", 2'h0, rdat[1:0])
        @(posedge core_clk);
        para <= 1'b0;
        $display("test engine done");
        for (int i = 0; i < 3; i++) begin
            pulse(4 + trip_q[i]);
            m_err = 1;
            tick(1);
            chk_act();
            `CHK("red", 1'b1, act_red)
            `CHK("enable", 1'b0, device_enable)
            `CHK("irq masked", 1'b0, irq)
            wr(REG_IRQ_MASK, 32'h0000_0001 << trip_q[i]);
            tick(0);
            `CHK("irq", 1'b1, irq)
            wr(REG_CTRL, 32'h0000_0001);
            rd(REG_STATE, rdat);
            `CHK("refused", 2'h0, rdat[1:0])
            `CHK("err flag", 1'b1, rdat[ST_ERR_LSB + trip_q[i]])
            if ($urandom % 2) wr(REG_CTRL, 32'h0000_0004);
            else pulse(7);
            m_err = 0;
            tick(1);
            chk_act();
            `CHK("re-enable", 1'b1, device_enable)
            wr(REG_IRQ_STATUS, 32'h0000_003f);
            tick(0);
            `CHK("irq clear", 1'b0, irq)
        end
        rd(8'h40, rdat);
        `CHK("unmapped", 32'h0000_0000, rdat)
        $display("test errors done");
        // power cycle: a temperature trip cleared by the chip reset alone
        pulse(6);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        `CHK("reset lamp", LAMP_DARK, access_lamp)
        m_err = 0;
        m_act = 0;
        tick(1);
        chk_act();
        `CHK("power cycle", 1'b1, device_enable)
        `CHK("acc after reset", LAMP_GREEN, access_lamp)
        `CHK("irq reset", 1'b0, irq)
        rd(REG_STATE, rdat);
        `CHK("temp flag", 1'b0, rdat[ST_ERR_LSB + EV_TEMP])
        $display("test reset done");
        complete_run();
    end
endmodule
